//--- rtl/seg_decoder_host.sv
// Host for one BCD seven-segment decoder stage with latch and blanking chain.
// Assumes software on AXI4-Lite and a decoder wired to the pin ports.
//
// Functional notes
// - Outside logic pulls the chain pin only low, open-collector style.
// - Each integer stage's chain output feeds the chain input of the next lower stage.
// - The most significant stage has its chain input tied low.
// - The least significant integer stage leaves its chain input high.
// - Fraction stages chain upward from the least significant one.
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`include "seg_host_params.svh"

module seg_decoder_host
(
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic [`SEG_ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [`SEG_ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output seg_host_pkg::digit_t digitOut,
	output logic latchEnableN,
	output logic lampCheckN,
	output logic blankChainInN,
	output logic fontTails,
	input wire logic chainFromUpstreamN,
	input wire logic blankChainOutNIn,
	output logic blankChainOutNOut,
	output logic blankChainOutNOeN,
	input wire seg_host_pkg::seg_t segIn
);
	import seg_host_pkg::*;

	localparam int OPEN_CYC =
		(`LATCH_OPEN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam int HOLD_CYC =
		(`LATCH_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

	// ****************************************
	// Helper functions
	// ****************************************

	// Word offset of a byte address
	function automatic logic [`SEG_ADDR_W-1:0] wordOf(
		input logic [`SEG_ADDR_W-1:0] addr);
		wordOf = {addr[`SEG_ADDR_W-1:2], 2'b00};
	endfunction

	// Byte-lane merge for lane zero
	function automatic logic [7:0] mergeByte(input logic [7:0] old,
		input logic [7:0] val, input logic strobe);
		mergeByte = strobe ? val : old;
	endfunction

	// Segments the decoder should show, order {g,f,e,d,c,b,a}
	function automatic seg_t expectSeg(input logic lampOn,
		input logic blanked, input digit_t dig, input logic tails);
		seg_t s;
		s = `SEG_ALL_OFF;
		case (dig)
			4'h0: s = 7'h3F;
			4'h1: s = tails ? 7'h06 : 7'h30;
			4'h2: s = 7'h5B;
			4'h3: s = 7'h4F;
			4'h4: s = 7'h66;
			4'h5: s = 7'h6D;
			4'h6: s = tails ? 7'h7D : 7'h7C;
			4'h7: s = 7'h07;
			4'h8: s = 7'h7F;
			4'h9: s = tails ? 7'h6F : 7'h67;
			default: s = `SEG_ALL_OFF;
		endcase
		if (blanked)
			s = `SEG_ALL_OFF;
		if (lampOn)
			s = `SEG_ALL_ON;
		expectSeg = s;
	endfunction

	// ****************************************
	// State
	// ****************************************
	logic awreadyReg, awreadyNext, bvalidReg, bvalidNext;
	logic [1:0] brespReg, brespNext, rrespReg, rrespNext;
	logic arreadyReg, arreadyNext, rvalidReg, rvalidNext;
	logic [31:0] rdataReg, rdataNext;
	logic [7:0] ctrlReg, ctrlNext;
	duty_t dutyReg, dutyNext;
	logic reqLoadReg, reqLoadNext;
	digit_t newDigitReg, newDigitNext;
	load_state_e stateReg, stateNext;
	logic [3:0] cntReg, cntNext;
	digit_t digitReg, digitNext;
	logic latchEnReg, latchEnNext;
	logic lampReg, lampNext, chainInReg, chainInNext;
	logic fontReg, fontNext, oeNReg, oeNNext;
	logic pinLevelReg, pinLevelNext, mismatchReg, mismatchNext;
	seg_t segSampleReg, segSampleNext;
	logic [1:0] role;
	pwm_if pwmLink();

	assign role = ctrlReg[`CTRL_ROLE_HI:`CTRL_ROLE_LO];

	// ****************************************
	// AXI4-Lite write channel
	// ****************************************

	// Accept address and data together, answer after the handshake
	always_comb
	begin
		awreadyNext = 1'b0;
		bvalidNext = bvalidReg;
		brespNext = brespReg;
		ctrlNext = ctrlReg;
		dutyNext = dutyReg;
		reqLoadNext = 1'b0;
		newDigitNext = newDigitReg;
		if (bvalidReg && bready)
			bvalidNext = 1'b0;
		if (awreadyReg)
		begin
			bvalidNext = 1'b1;
			brespNext = `RESP_OKAY;
			case (wordOf(awaddr))
				`SEG_OFF_CTRL: ctrlNext = mergeByte(ctrlReg, wdata[7:0], wstrb[0]);
				`SEG_OFF_DIGIT:
				begin
					if (wstrb[0])
					begin
						newDigitNext = wdata[3:0];
						reqLoadNext = 1'b1;
					end
				end
				`SEG_OFF_DUTY: dutyNext = mergeByte(dutyReg, wdata[7:0], wstrb[0]);
				`SEG_OFF_STATUS: brespNext = `RESP_OKAY;
				default: brespNext = `RESP_SLVERR;
			endcase
		end
		else if (!bvalidReg && awvalid && wvalid)
			awreadyNext = 1'b1;
	end

	// Register the write side
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			awreadyReg <= 1'b0;
			bvalidReg <= 1'b0;
			brespReg <= `RESP_OKAY;
			ctrlReg <= `CTRL_RESET;
			dutyReg <= `DUTY_RESET;
			reqLoadReg <= 1'b0;
			newDigitReg <= `DIGIT_RESET;
		end
		else if (ce)
		begin
			awreadyReg <= awreadyNext;
			bvalidReg <= bvalidNext;
			brespReg <= brespNext;
			ctrlReg <= ctrlNext;
			dutyReg <= dutyNext;
			reqLoadReg <= reqLoadNext;
			newDigitReg <= newDigitNext;
		end
	end

	// ****************************************
	// AXI4-Lite read channel
	// ****************************************

	// One read at a time, data one cycle after the address handshake
	always_comb
	begin
		arreadyNext = 1'b0;
		rvalidNext = rvalidReg;
		rdataNext = rdataReg;
		rrespNext = rrespReg;
		if (rvalidReg && rready)
			rvalidNext = 1'b0;
		if (arreadyReg)
		begin
			rvalidNext = 1'b1;
			rrespNext = `RESP_OKAY;
			rdataNext = 32'h0000_0000;
			case (wordOf(araddr))
				`SEG_OFF_CTRL: rdataNext[7:0] = ctrlReg;
				`SEG_OFF_DIGIT: rdataNext[3:0] = digitReg;
				`SEG_OFF_DUTY: rdataNext[7:0] = dutyReg;
				`SEG_OFF_STATUS:
				begin
					rdataNext[`STAT_BUSY] = (stateReg != ST_IDLE);
					rdataNext[`STAT_PIN] = pinLevelReg;
					rdataNext[`STAT_MISMATCH] = mismatchReg;
					rdataNext[`STAT_SEG_LO +: 7] = segSampleReg;
					rdataNext[`STAT_DIGIT_LO +: 4] = digitReg;
				end
				default: rrespNext = `RESP_SLVERR;
			endcase
		end
		else if (!rvalidReg && arvalid)
			arreadyNext = 1'b1;
	end

	// Register the read side
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			arreadyReg <= 1'b0;
			rvalidReg <= 1'b0;
			rdataReg <= 32'h0000_0000;
			rrespReg <= `RESP_OKAY;
		end
		else if (ce)
		begin
			arreadyReg <= arreadyNext;
			rvalidReg <= rvalidNext;
			rdataReg <= rdataNext;
			rrespReg <= rrespNext;
		end
	end

	// ****************************************
	// Digit latch load sequence
	// ****************************************

	// Open the latch, present the digit, then close it and hold the data
	always_comb
	begin
		stateNext = stateReg;
		cntNext = cntReg;
		digitNext = digitReg;
		latchEnNext = latchEnReg;
		case (stateReg)
			ST_IDLE:
			begin
				latchEnNext = !ctrlReg[`CTRL_TRANSP];
				if (reqLoadReg)
				begin
					digitNext = newDigitReg;
					latchEnNext = 1'b0;
					cntNext = 4'(OPEN_CYC - 1);
					stateNext = ST_OPEN;
				end
			end
			ST_OPEN:
			begin
				if (cntReg == 4'h0)
				begin
					latchEnNext = !ctrlReg[`CTRL_TRANSP];
					cntNext = 4'(HOLD_CYC - 1);
					stateNext = ST_HOLD;
				end
				else
					cntNext = cntReg - 4'h1;
			end
			ST_HOLD:
			begin
				// Digit stays put past the rising enable edge
				if (cntReg == 4'h0)
					stateNext = ST_IDLE;
				else
					cntNext = cntReg - 4'h1;
			end
			default: stateNext = ST_IDLE;
		endcase
	end

	// Register the load sequence
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			stateReg <= ST_IDLE;
			cntReg <= 4'h0;
			digitReg <= `DIGIT_RESET;
			latchEnReg <= 1'b1;
		end
		else if (ce)
		begin
			stateReg <= stateNext;
			cntReg <= cntNext;
			digitReg <= digitNext;
			latchEnReg <= latchEnNext;
		end
	end

	// ****************************************
	// Device pins and checking
	// ****************************************
	assign pwmLink.enable = ctrlReg[`CTRL_PWM];
	assign pwmLink.duty = dutyReg;

	// Brightness modulation of the blanking pin
	blank_pwm dimmer
	(
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.pwm(pwmLink.gen)
	);

	// Static pin levels, open-drain pull and decode check
	always_comb
	begin
		lampNext = !ctrlReg[`CTRL_LAMP];
		fontNext = ctrlReg[`CTRL_FONT];
		case (role)
			`ROLE_MOST: chainInNext = 1'b0;
			`ROLE_LS_INT: chainInNext = 1'b1;
			`ROLE_FRACT_END: chainInNext = 1'b0;
			`ROLE_FOLLOW: chainInNext = chainFromUpstreamN;
			default: chainInNext = 1'b1;
		endcase
		// Pin only ever pulled low, never driven high
		oeNNext = !(ctrlReg[`CTRL_BLANK] || pwmLink.pull);
		pinLevelNext = blankChainOutNIn;
		segSampleNext = segIn;
		// Low pin blanks a zero under chain low or an external pull
		mismatchNext = (stateReg == ST_IDLE) && (segSampleReg !=
			expectSeg(!lampReg, !pinLevelReg, digitReg, fontReg));
		if (!chainInReg && digitReg == 4'h0 && lampReg && pinLevelReg
			&& stateReg == ST_IDLE)
			mismatchNext = 1'b1;
	end

	// Register the pin drivers and samples
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			lampReg <= 1'b1;
			chainInReg <= 1'b1;
			fontReg <= 1'b0;
			oeNReg <= 1'b1;
			pinLevelReg <= 1'b1;
			segSampleReg <= `SEG_ALL_OFF;
			mismatchReg <= 1'b0;
		end
		else if (ce)
		begin
			lampReg <= lampNext;
			chainInReg <= chainInNext;
			fontReg <= fontNext;
			oeNReg <= oeNNext;
			pinLevelReg <= pinLevelNext;
			segSampleReg <= segSampleNext;
			mismatchReg <= mismatchNext;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign awready = awreadyReg;
	assign wready = awreadyReg;
	assign bvalid = bvalidReg;
	assign bresp = brespReg;
	assign arready = arreadyReg;
	assign rvalid = rvalidReg;
	assign rdata = rdataReg;
	assign rresp = rrespReg;
	assign digitOut = digitReg;
	assign latchEnableN = latchEnReg;
	assign lampCheckN = lampReg;
	assign blankChainInN = chainInReg;
	assign fontTails = fontReg;
	assign blankChainOutNOut = 1'b0; // Open-drain data is always low
	assign blankChainOutNOeN = oeNReg;

endmodule

//--- rtl/seg_host_params.svh
// Offsets, field positions, reset values and timing for the display host.
// Assumes a 250 MHz clock and a 32-bit AXI4-Lite register port.
`ifndef SEG_HOST_PARAMS_SVH
`define SEG_HOST_PARAMS_SVH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define SEG_ADDR_W 5
`define SEG_OFF_CTRL 5'h00
`define SEG_OFF_DIGIT 5'h04
`define SEG_OFF_DUTY 5'h08
`define SEG_OFF_STATUS 5'h0C

// ****************************************
// Control fields
// ****************************************
`define CTRL_TRANSP 0
`define CTRL_LAMP 1
`define CTRL_ROLE_LO 2
`define CTRL_ROLE_HI 3
`define CTRL_BLANK 4
`define CTRL_PWM 5
`define CTRL_FONT 6
`define CTRL_RESET 8'h00

// Chain roles of the attached stage
`define ROLE_MOST 2'h0
`define ROLE_LS_INT 2'h1
`define ROLE_FRACT_END 2'h2
`define ROLE_FOLLOW 2'h3

// ****************************************
// Status fields
// ****************************************
`define STAT_BUSY 0
`define STAT_PIN 1
`define STAT_MISMATCH 2
`define STAT_SEG_LO 8
`define STAT_DIGIT_LO 16

// ****************************************
// Reset values and segment patterns
// ****************************************
`define DIGIT_RESET 4'h0
`define DUTY_RESET 8'h00
`define SEG_ALL_ON 7'h7F
`define SEG_ALL_OFF 7'h00

// ****************************************
// Bus answers
// ****************************************
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 4
`define LATCH_OPEN_NS 20
`define LATCH_HOLD_NS 20

`endif

//--- rtl/seg_host_pkg.sv
// Types shared by the display host and its brightness generator.
// Assumes nothing beyond a SystemVerilog compiler.
package seg_host_pkg;

	typedef logic [3:0] digit_t;
	typedef logic [6:0] seg_t;
	typedef logic [7:0] duty_t;

	// Latch load sequence
	typedef enum logic [1:0] {ST_IDLE, ST_OPEN, ST_HOLD} load_state_e;

endpackage

//--- rtl/pwm_if.sv
// Link between the host core and its brightness generator.
// Assumes both ends run on the same clock.
interface pwm_if;

	logic enable;
	seg_host_pkg::duty_t duty;
	logic pull;

	modport ctl (output enable, output duty, input pull);
	modport gen (input enable, input duty, output pull);

endinterface

//--- rtl/blank_pwm.sv
// Brightness generator: a pull request on the blanking pin with set duty.
// Assumes the host turns the request into an open-drain drive.
module blank_pwm
(
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	pwm_if.gen pwm
);
	import seg_host_pkg::*;

	duty_t cntReg;
	duty_t cntNext;
	logic pullReg;
	logic pullNext;

	// ****************************************
	// Period counter and pull decision
	// ****************************************

	// Duty is the lit share of a 256-cycle period
	always_comb
	begin
		cntNext = cntReg + 8'h01;
		pullNext = pwm.enable && (cntReg >= pwm.duty);
	end

	// Register the counter and the pull request
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			cntReg <= 8'h00;
			pullReg <= 1'b0;
		end
		else if (ce)
		begin
			cntReg <= cntNext;
			pullReg <= pullNext;
		end
	end

	assign pwm.pull = pullReg;

endmodule

//--- sim/seg_decoder_host_assertions.sv
// Concurrent checks on the display host's bus handshakes and latch pins.
// Assumes a bind to the host top, one clock and an active-high reset.
module seg_decoder_host_checker
(
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic awvalid,
	input wire logic wvalid,
	input wire logic awready,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire seg_host_pkg::digit_t digitOut,
	input wire logic latchEnableN,
	input wire logic blankChainOutNOut
);
	import seg_host_pkg::*;

	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);

	// Steps of a bus request and of a latch load
	sequence writeTaken;
		ce && awvalid && wvalid && !bvalid && !awready;
	endsequence
	sequence readTaken;
		ce && arvalid && !rvalid && !arready;
	endsequence
	sequence openWindow;
		!latchEnableN [*5];
	endsequence

	latch_open_a: assert property ($fell(latchEnableN) |-> openWindow)
		else $error("latch closed before its open window ended");
	digit_hold_a: assert property (latchEnableN |-> $stable(digitOut))
		else $error("digit moved while the latch was closed");
	pull_only_a: assert property (!blankChainOutNOut)
		else $error("chain pin data is not low");
	write_take_a: assert property (writeTaken |=> awready && wready)
		else $error("write not taken on the next cycle");
	write_answer_a: assert property (awready |=> bvalid && !awready)
		else $error("write answer late");
	read_take_a: assert property (readTaken |=> arready)
		else $error("read not taken on the next cycle");
	read_answer_a: assert property (arready |=> rvalid && !arready)
		else $error("read answer late");
	write_refuse_a: assert property (bvalid |-> !awready)
		else $error("write taken while a response waits");
	read_refuse_a: assert property (rvalid |-> !arready)
		else $error("read taken while data waits");
endmodule

//--- sim/bcd_stage_model.sv
// Behavioural model of one BCD seven-segment decoder stage.
// Assumes the bench resolves the wired chain pin and feeds its level back.
module bcd_stage_model
(
	input wire seg_host_pkg::digit_t digit,
	input wire logic latchEnableN,
	input wire logic lampCheckN,
	input wire logic blankChainInN,
	input wire logic fontTails,
	input wire logic pinLevel,
	output logic pullLow,
	output seg_host_pkg::seg_t seg
);
	timeunit 1ns;
	timeprecision 1ps;
	import seg_host_pkg::*;

	localparam seg_t FontL [10] = '{7'h3F, 7'h30, 7'h5B, 7'h4F, 7'h66,
		7'h6D, 7'h7C, 7'h07, 7'h7F, 7'h67};
	localparam seg_t FontR [10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66,
		7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};
	digit_t heldDigit;

	// Pattern of a code in either font, blank above nine
	function automatic seg_t fontSeg(input digit_t d, input logic tails);
		return d > 4'h9 ? 7'h00 : tails ? FontR[d] : FontL[d];
	endfunction

	// Input latch, open while enable is low
	always_latch
		if (!latchEnableN)
			heldDigit <= digit;

	// Chain output pulls low for a stored zero with chain input low
	assign pullLow = lampCheckN && !blankChainInN &&
		heldDigit == 4'h0;

	// Lamp check first, then pin blanking, then the font
	always_comb
		if (!lampCheckN)
			seg = 7'h7F;
		else if (!pinLevel)
			seg = 7'h00;
		else
			seg = fontSeg(heldDigit, fontTails);
endmodule

//--- sim/tb_seg_decoder_host.sv
// Self-checking bench for the display host driving a decoder stage model.
// Assumes the host, its package, header, checker and model are compiled.
`include "seg_host_params.svh"
module tb_seg_decoder_host;
	timeunit 1ns;
	timeprecision 1ps;
	import seg_host_pkg::*;

	logic clock, rst, awvalid, wvalid, bready, arvalid, rready, upN, ce;
	logic awready, wready, bvalid, arready, rvalid, pinOut, pinOeN;
	logic latchEnableN, lampCheckN, blankChainInN, fontTails, pullLow;
	logic [4:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] bresp, rresp, resp;
	digit_t digitOut;
	seg_t segIn;
	duty_t pwmDuty [3] = '{8'hFF, 8'h80, 8'h00};
	int errors = 0;
	int n_compared = 0;
	int cnt;
	// Chain pin with pull-up: low if the stage or the host pulls it
	wire logic pinLevel = !(pullLow || !pinOeN);

	seg_decoder_host seg_decoder_host_inst
	(
		.clock, .rst, .ce, .awaddr, .awvalid, .awready, .wdata,
		.wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .digitOut,
		.latchEnableN, .lampCheckN, .blankChainInN, .fontTails,
		.chainFromUpstreamN(upN), .blankChainOutNIn(pinLevel),
		.blankChainOutNOut(pinOut), .blankChainOutNOeN(pinOeN), .segIn
	);

	bcd_stage_model bcd_stage_model_inst
	(
		.digit(digitOut), .latchEnableN, .lampCheckN, .blankChainInN,
		.fontTails, .pinLevel, .pullLow, .seg(segIn)
	);

	// Free-running 250 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_compared++;
		if (seen !== want)
		begin
			errors++;
			$display("MISMATCH %0t seen %h want %h", $time, seen, want);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d,
		input logic [1:0] want);
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
			@(posedge clock);
		while (awready !== 1'b1);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		while (bvalid !== 1'b1)
			@(posedge clock);
		bready <= 1'b0;
		check({30'h0, bresp}, {30'h0, want});
	endtask

	task automatic axiRead(input logic [4:0] a);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
			@(posedge clock);
		while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1)
			@(posedge clock);
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	task automatic rdc(input logic [4:0] a, input logic [31:0] want,
		input logic [1:0] wantResp);
		axiRead(a);
		check(rd, want);
		check({30'h0, resp}, {30'h0, wantResp});
	endtask

	// Poll until the load is idle, then take a fresh status word
	task automatic settle();
		rd = 32'h1;
		for (int i = 0; i < 20 && rd[`STAT_BUSY] !== 1'b0; i++)
			axiRead(`SEG_OFF_STATUS);
		axiRead(`SEG_OFF_STATUS);
	endtask

	task automatic show(input logic [6:0] c, input digit_t d, input seg_t s,
		input logic p);
		wr(`SEG_OFF_CTRL, {25'h0, c}, `RESP_OKAY);
		wr(`SEG_OFF_DIGIT, {28'h0, d}, `RESP_OKAY);
		settle();
		check(rd, {12'h000, d, 1'b0, s, 6'h00, p, 1'b0});
	endtask

	task automatic conclude();
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial
	begin
		repeat (60000) @(posedge clock);
		errors++;
		conclude();
	end

	// Main sequence
	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready, upN, ce} = 7'h03;
		{awaddr, araddr, wdata} = 42'h0;
		rst = 1'b1;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		for (int i = 0; i < 3; i++)
			rdc(5'(4 * i), 32'h0, `RESP_OKAY);
		rdc(5'h10, 32'h0, `RESP_SLVERR);
		wr(5'h14, 32'h1, `RESP_SLVERR);
		wr(`SEG_OFF_STATUS, 32'hFFFF_FFFF, `RESP_OKAY);
		wr(`SEG_OFF_DUTY, 32'hFFFF_FFFF, `RESP_OKAY);
		rdc(`SEG_OFF_DUTY, 32'h0000_00FF, `RESP_OKAY);
		for (int f = 0; f < 2; f++)
			for (int d = 0; d < 16; d++)
				show({1'(f), 6'h04}, 4'(d),
					bcd_stage_model_inst.fontSeg(4'(d), 1'(f)), 1'b1);
		// A second load while busy is dropped
		wr(`SEG_OFF_DIGIT, 32'h3, `RESP_OKAY);
		wr(`SEG_OFF_DIGIT, 32'h8, `RESP_OKAY);
		settle();
		check(rd, {12'h000, 4'h3, 1'b0, 7'h4F, 8'h02});
		show(7'h00, 4'h0, 7'h00, 1'b0);
		show(7'h00, 4'h7, 7'h07, 1'b1);
		show(7'h08, 4'h0, 7'h00, 1'b0);
		show(7'h0C, 4'h0, 7'h3F, 1'b1);
		upN <= 1'b0;
		show(7'h0C, 4'h0, 7'h00, 1'b0);
		show(7'h14, 4'h5, 7'h00, 1'b0);
		show(7'h16, 4'h5, 7'h7F, 1'b0);
		wr(`SEG_OFF_CTRL, 32'h05, `RESP_OKAY);
		settle();
		check({31'h0, latchEnableN}, 32'h0);
		// Dimming: pulled cycles per period are 256 minus the duty
		for (int k = 0; k < 3; k++)
		begin
			wr(`SEG_OFF_DUTY, {24'h0, pwmDuty[k]}, `RESP_OKAY);
			wr(`SEG_OFF_CTRL, 32'h24, `RESP_OKAY);
			// Let the pull request reach the pin before counting
			repeat (2) @(posedge clock);
			cnt = 0;
			repeat (256)
				@(posedge clock) cnt += int'(!pinOeN);
			check(32'(cnt), 32'h100 - {24'h0, pwmDuty[k]});
		end
		wr(`SEG_OFF_CTRL, 32'h04, `RESP_OKAY);
		repeat (3) @(posedge clock);
		check({31'h0, pinOeN}, 32'h1);
		// Clock enable low freezes the open latch window
		wr(`SEG_OFF_DIGIT, 32'h2, `RESP_OKAY);
		ce <= 1'b0;
		repeat (20) @(posedge clock);
		check({31'h0, latchEnableN}, 32'h0);
		ce <= 1'b1;
		settle();
		check(rd, {12'h000, 4'h2, 1'b0, 7'h5B, 8'h02});
		conclude();
	end
endmodule

bind seg_decoder_host seg_decoder_host_checker seg_decoder_host_checker_inst
(
	.clock, .rst, .ce, .awvalid, .wvalid, .awready, .wready, .bvalid,
	.arvalid, .arready, .rvalid, .digitOut, .latchEnableN, .blankChainOutNOut
);
